// file: inc/sats_pkg.sv
// shared constants and carrier types for the smoke alarm timing sequencer
// assumes a single 100 MHz ref_clk; slot numbers index a 4096-period frame
package sats_pkg;

    // time base: the rc oscillator period is emulated by a divider
    localparam int CLK_PERIOD_NS  = 10;
    localparam int OSC_PERIOD_US  = 7900;   // typical oscillator period
    localparam int DISCH_MIN_US   = 94;     // discharge phase, least
    localparam int DISCH_MAX_US   = 116;    // discharge phase, most
    localparam int DISCH_NOM_US   = 105;    // discharge phase, nominal
    localparam int OSC_PERIOD_CYC = OSC_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int DISCH_CYC      = DISCH_NOM_US * 1000 / CLK_PERIOD_NS;

    // period frame and slot positions inside it
    localparam int              FRAME_W        = 12;
    localparam logic [11:0]     LED_STBY_SLOT  = 12'h000;
    localparam logic [11:0]     FAST_LED_MASK  = 12'h03f;
    localparam logic [11:0]     FAST_LED_SLOT  = 12'h000;
    localparam logic [11:0]     SMOKE_MASK     = 12'h3ff;
    localparam logic [11:0]     SMOKE_SLOT     = 12'h120;  // off flash grid
    localparam logic [11:0]     CHAMB_SLOT     = 12'h800;
    localparam logic [11:0]     LOWSUP_SLOT    = 12'h004;
    localparam logic [11:0]     LS_CHIRP_SLOT  = 12'h001;
    localparam logic [11:0]     CH_CHIRP_SLOT  = 12'h801;
    localparam logic [11:0]     PB_MASK        = 12'h07f;
    localparam logic [11:0]     PB_SLOT        = 12'h020;
    localparam logic [11:0]     IO_SAMPLE_SLOT = 12'h040;

    // confirmation counts
    localparam logic [1:0]      DET_CONFIRM    = 2'h2;
    localparam logic [1:0]      REMOTE_CONFIRM = 2'h2;

    // temporal horn pattern lengths in oscillator periods
    localparam logic [7:0]      SOUND_LEN      = 8'h40;
    localparam logic [7:0]      SHORT_GAP_LEN  = 8'h40;
    localparam logic [7:0]      LONG_GAP_LEN   = 8'hc0;

    // sensed levels from the analog side and the pins
    typedef struct packed {
        logic testButton;   // pushbutton level, high = pressed
        logic smokeDetect;  // comparator result at end of emitter pulse
        logic lowSupply;    // low-supply comparator result
        logic ioIn;         // interconnect line level
    } sats_sense_t;

endpackage

// file: core/sats_osc_div.sv
// divider that stands in for the rc oscillator: charge then discharge
// assumes PERIOD_CYC > DISCH_CYC >= 1 and a synchronous active-low reset
module sats_osc_div #(
    parameter int PERIOD_CYC = sats_pkg::OSC_PERIOD_CYC,
    parameter int DISCH_CYC  = sats_pkg::DISCH_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      periodEnd,
    output logic      dischargeNext
);
    import sats_pkg::*;

    localparam int            CW         = $clog2(PERIOD_CYC);
    localparam logic [CW-1:0] LAST       = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] CHARGE_END = CW'(PERIOD_CYC - DISCH_CYC);

    logic [CW-1:0] phaseCnt_q;
    logic [CW-1:0] phaseCnt_d;
    int            sinceEnd;
    logic          seenEnd;

    // discharge is the tail of each period; the flag looks one cycle ahead
    assign periodEnd     = (phaseCnt_q == LAST);
    assign phaseCnt_d    = periodEnd ? '0 : phaseCnt_q + 1'b1;
    assign dischargeNext = (phaseCnt_d >= CHARGE_END);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phaseCnt_q <= '0;
        end else begin
            phaseCnt_q <= phaseCnt_d;
        end
    end

    // helper: cycles since the last period end, for the check below
    always_ff @(posedge ref_clk) begin
        if (!rst_n || periodEnd) begin
            sinceEnd <= 0;
        end else begin
            sinceEnd <= sinceEnd + 1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seenEnd <= 1'b0;
        end else if (periodEnd) begin
            seenEnd <= 1'b1;
        end
    end

    period_spacing_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        periodEnd && seenEnd |-> sinceEnd == PERIOD_CYC - 1)
        else $error("oscillator period is not the set count");

endmodule

// file: core/sats_temporal.sv
// temporal horn pattern: three bursts with short gaps, then a long gap
// assumes step is a one-cycle pulse once per oscillator period
module sats_temporal (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic alarmOn,
    input  wire logic step,
    output logic      soundNext
);
    import sats_pkg::*;

    typedef enum logic [2:0] {
        BURST1, GAP1, BURST2, GAP2, BURST3, LONG_GAP
    } sats_seg_t;

    sats_seg_t  seg_q;
    logic [7:0] within_q;
    logic [7:0] segLen;
    logic       segDone;

    // length of the segment and whether it sounds
    always_comb begin
        segLen    = SOUND_LEN;
        soundNext = 1'b0;
        case (seg_q)
            BURST1, BURST2, BURST3: begin
                segLen    = SOUND_LEN;
                soundNext = alarmOn;
            end
            GAP1, GAP2: begin
                segLen = SHORT_GAP_LEN;
            end
            LONG_GAP: begin
                segLen = LONG_GAP_LEN;
            end
            default: begin
                segLen = SOUND_LEN;
            end
        endcase
    end

    assign segDone = step && (within_q == segLen - 8'h01);

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !alarmOn) begin
            seg_q    <= BURST1;
            within_q <= '0;
        end else if (segDone) begin
            within_q <= '0;
            case (seg_q)
                BURST1:   seg_q <= GAP1;
                GAP1:     seg_q <= BURST2;
                BURST2:   seg_q <= GAP2;
                GAP2:     seg_q <= BURST3;
                BURST3:   seg_q <= LONG_GAP;
                default:  seg_q <= BURST1;
            endcase
        end else if (step) begin
            within_q <= within_q + 8'h01;
        end
    end

    sequence s_segFull;
        $past(step) && $past(within_q) == $past(segLen) - 8'h01;
    endsequence

    seg_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(seg_q) && $past(alarmOn) && alarmOn |-> s_segFull)
        else $error("horn segment ended early or late");

    long_after_third_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(seg_q) && seg_q == LONG_GAP |-> $past(seg_q) == BURST3)
        else $error("long silence not after third burst");

endmodule

// file: core/sats_sequencer.sv
// timing sequencer of a photoelectric smoke detector
// assumes sense inputs synchronous to ref_clk; pin levels handled outside
module sats_sequencer #(
    parameter int OSC_PERIOD_CYC = sats_pkg::OSC_PERIOD_CYC,
    parameter int DISCH_CYC      = sats_pkg::DISCH_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire sats_pkg::sats_sense_t sense,
    output logic                       emitterDrive,
    output logic                       strobeOut,
    output logic                       indicatorOutput,
    output logic                       indicatorOutputOe,
    output logic                       hornDrive,
    output logic                       ioOut,
    output logic                       ioOe,
    output logic                       highGainCap,
    output logic                       normalGainCap,
    output logic                       hysteresisBoost
);
    import sats_pkg::*;

    logic               periodEnd;
    logic               dischargeNext;
    logic               soundNext;
    logic [FRAME_W-1:0] perCnt_q;
    logic [FRAME_W-1:0] perCnt_d;
    logic               testMode_q;
    logic               testMode_d;
    logic               localSmoke_q;
    logic               remoteSmoke_q;
    logic               lowFlag_q;
    logic               degraded_q;
    logic [1:0]         hitCnt_q;
    logic [1:0]         missCnt_q;
    logic [1:0]         remoteHits_q;
    logic               ioPrev_q;
    logic               ioEdge_q;
    logic               emitter_q;
    logic               strobe_q;
    logic               led_q;
    logic               horn_q;
    logic               ioDrive_q;
    logic               highGain_q;
    logic               normalGain_q;
    logic               boost_q;
    logic               emitSlot_q;
    logic               chambSlot_q;
    logic               lowSlot_q;
    logic               alarmNow;
    logic               smokeSlotN;
    logic               pbSlotN;
    logic               chambSlotN;
    logic               lowSlotN;
    logic               ledN;
    logic               chirpN;
    logic               ioSample;
    logic               detSample;
    int                 emitRun;

    sats_osc_div #(
        .PERIOD_CYC    (OSC_PERIOD_CYC),
        .DISCH_CYC     (DISCH_CYC)
    ) u_osc (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .periodEnd     (periodEnd),
        .dischargeNext (dischargeNext)
    );

    sats_temporal u_temporal (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .alarmOn   (alarmNow),
        .step      (periodEnd),
        .soundNext (soundNext)
    );

    // next-period frame position; button level at the period end sets the next period's test mode
    assign perCnt_d   = periodEnd ? perCnt_q + 1'b1 : perCnt_q;
    assign testMode_d = periodEnd ? sense.testButton : testMode_q;
    assign alarmNow   = localSmoke_q || remoteSmoke_q;

    // low-supply slot, only without local or remote smoke
    always_comb begin
        smokeSlotN = !testMode_d && ((perCnt_d & SMOKE_MASK) == SMOKE_SLOT);
        pbSlotN    = testMode_d && ((perCnt_d & PB_MASK) == PB_SLOT);
        chambSlotN = !localSmoke_q && !testMode_d && (perCnt_d == CHAMB_SLOT);
        lowSlotN   = !alarmNow && !testMode_d && (perCnt_d == LOWSUP_SLOT);
    end

    always_comb begin
        if (localSmoke_q || testMode_d) begin
            ledN = ((perCnt_d & FAST_LED_MASK) == FAST_LED_SLOT);
        end else begin
            ledN = !remoteSmoke_q && (perCnt_d == LED_STBY_SLOT);
        end
    end

    // trouble chirp slots; the low-supply one sits next to the flash
    assign chirpN = !alarmNow &&
                    ((lowFlag_q && perCnt_d == LS_CHIRP_SLOT) ||
                     (degraded_q && perCnt_d == CH_CHIRP_SLOT));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            perCnt_q    <= '0;
            testMode_q  <= 1'b0;
            strobe_q    <= 1'b0;
            emitSlot_q  <= 1'b0;
            chambSlot_q <= 1'b0;
            lowSlot_q   <= 1'b0;
            led_q       <= 1'b0;
            horn_q      <= 1'b0;
            highGain_q  <= 1'b0;
            normalGain_q <= 1'b1;
        end else if (periodEnd) begin
            perCnt_q    <= perCnt_d;
            testMode_q  <= testMode_d;
            strobe_q    <= smokeSlotN || pbSlotN || chambSlotN || lowSlotN;
            emitSlot_q  <= smokeSlotN || pbSlotN || chambSlotN;
            chambSlot_q <= chambSlotN;
            lowSlot_q   <= lowSlotN;
            led_q       <= ledN;
            horn_q      <= alarmNow ? soundNext : chirpN;
            // high gain only for test and chamber check
            highGain_q  <= testMode_d || chambSlotN;
            normalGain_q <= !(testMode_d || chambSlotN);
        end
    end

    // emitter over the discharge phase only
    // hysteresis boost rides on the pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            emitter_q <= 1'b0;
            boost_q   <= 1'b0;
        end else begin
            emitter_q <= dischargeNext && emitSlot_q && !led_q && !horn_q;
            boost_q   <= dischargeNext && emitSlot_q && !led_q && !horn_q &&
                         localSmoke_q && !highGain_q;
        end
    end

    // detection result is taken as the emitter pulse ends
    assign detSample = periodEnd && emitter_q && !chambSlot_q;

    // two confirmed hits raise local smoke, two misses drop it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hitCnt_q     <= '0;
            missCnt_q    <= '0;
            localSmoke_q <= 1'b0;
        end else if (detSample && sense.smokeDetect) begin
            missCnt_q <= '0;
            if (hitCnt_q != DET_CONFIRM) begin
                hitCnt_q <= hitCnt_q + 2'h1;
            end
            if (hitCnt_q == DET_CONFIRM - 2'h1) begin
                localSmoke_q <= 1'b1;
            end
        end else if (detSample) begin
            hitCnt_q <= '0;
            if (missCnt_q != DET_CONFIRM) begin
                missCnt_q <= missCnt_q + 2'h1;
            end
            if (missCnt_q == DET_CONFIRM - 2'h1) begin
                localSmoke_q <= 1'b0;
            end
        end
    end

    // trouble flags refreshed at the end of their own test periods
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lowFlag_q  <= 1'b0;
            degraded_q <= 1'b0;
        end else if (periodEnd) begin
            if (lowSlot_q) begin
                lowFlag_q <= sense.lowSupply;
            end
            if (chambSlot_q && emitter_q) begin
                degraded_q <= !sense.smokeDetect;
            end
        end
    end

    // edge latch; own drive masks the input
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ioPrev_q <= 1'b0;
            ioEdge_q <= 1'b0;
        end else begin
            ioPrev_q <= sense.ioIn;
            if (ioDrive_q) begin
                ioEdge_q <= 1'b0;
            end else if (sense.ioIn && !ioPrev_q) begin
                ioEdge_q <= 1'b1;  // an edge wins over the sample clear
            end else if (ioSample && !sense.ioIn) begin
                ioEdge_q <= 1'b0;
            end
        end
    end

    assign ioSample = periodEnd && !localSmoke_q && !testMode_q &&
                      ((perCnt_q & PB_MASK) == IO_SAMPLE_SLOT);

    // two samples with the line high start the remote alarm
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ioDrive_q) begin
            remoteHits_q  <= '0;
            remoteSmoke_q <= 1'b0;
        end else if (ioSample && ioEdge_q && sense.ioIn) begin
            if (remoteHits_q != REMOTE_CONFIRM) begin
                remoteHits_q <= remoteHits_q + 2'h1;
            end
            if (remoteHits_q == REMOTE_CONFIRM - 2'h1) begin
                remoteSmoke_q <= 1'b1;
            end
        end else if (ioSample) begin
            remoteHits_q  <= '0;
            remoteSmoke_q <= 1'b0;
        end
    end

    // local smoke, real or simulated, drives the line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ioDrive_q <= 1'b0;
        end else begin
            ioDrive_q <= localSmoke_q;
        end
    end

    // outputs straight from flops; indicator is open drain, pulls low
    assign emitterDrive      = emitter_q;
    assign strobeOut         = strobe_q;
    assign indicatorOutput   = 1'b0;
    assign indicatorOutputOe = led_q;
    assign hornDrive         = horn_q;
    assign ioOut             = ioDrive_q;
    assign ioOe              = ioDrive_q;
    assign highGainCap       = highGain_q;
    // normal gain whenever high gain is off
    assign normalGainCap     = normalGain_q;
    assign hysteresisBoost   = boost_q;

    // helper: length of the current emitter pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !emitter_q) begin
            emitRun <= 0;
        end else begin
            emitRun <= emitRun + 1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_boundary;
        $past(periodEnd);
    endsequence

    emitter_width_a: assert property (
        $fell(emitter_q) |-> emitRun == DISCH_CYC)
        else $error("emitter pulse width differs from discharge");
    emitter_clear_a: assert property (
        emitter_q |-> !led_q && !horn_q)
        else $error("emitter overlaps indicator or horn");
    led_boundary_a: assert property (
        $changed(led_q) |-> s_boundary)
        else $error("indicator changed inside a period");
    led_remote_dark_a: assert property (
        $past(periodEnd && remoteSmoke_q && !localSmoke_q && !testMode_d)
        |-> !led_q)
        else $error("indicator flashed during remote-only smoke");
    strobe_boundary_a: assert property (
        $changed(strobe_q) |-> s_boundary)
        else $error("strobe changed inside a period");
    lowsup_apart_a: assert property (
        lowSlot_q |-> strobe_q && !horn_q && !testMode_q && !emitSlot_q)
        else $error("low-supply test meets another activity");
    chirp_slot_a: assert property (
        $past(periodEnd && !alarmNow) && horn_q |->
            perCnt_q == LS_CHIRP_SLOT || perCnt_q == CH_CHIRP_SLOT)
        else $error("chirp outside its slot");
    remote_sample_a: assert property (
        $rose(remoteSmoke_q) |-> $past(ioSample && ioEdge_q && sense.ioIn))
        else $error("remote alarm without a sampled edge");
    io_ignore_a: assert property (
        ioDrive_q |=> !remoteSmoke_q && !ioEdge_q)
        else $error("interconnect input taken while driving");
    io_drive_a: assert property (
        $rose(ioDrive_q) |-> $past(localSmoke_q))
        else $error("interconnect driven without local smoke");
    high_gain_cause_a: assert property (
        highGain_q |-> testMode_q || perCnt_q == CHAMB_SLOT)
        else $error("high gain outside test or chamber check");
    boost_cause_a: assert property (
        boost_q |-> emitter_q && localSmoke_q && !highGain_q)
        else $error("gain boost without local smoke pulse");
    reset_state_a: assert property (disable iff (1'b0)
        $past(!rst_n) |-> perCnt_q == '0 && !ioDrive_q && !alarmNow)
        else $error("reset left counters or alarm state");

endmodule

// file: verification/sats_far_side.sv
// far-side model: smoke chamber photodiode path and a remote detector unit
// assumes the sequencer outputs are registered on ref_clk
module sats_far_side (
    input  wire logic ref_clk,
    input  wire logic emitterDrive,
    input  wire logic highGainCap,
    input  wire logic ioOut,
    input  wire logic ioOe,
    input  wire logic smokeOn,
    input  wire logic remoteOn,
    output logic      smokeDet,
    output logic      ioLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_q = 1'b0;
    // comparator output is noise outside the emitter pulse
    always_ff @(posedge ref_clk) begin
        toggle_q <= ~toggle_q;
    end
    // high gain makes background reflections look like smoke
    assign smokeDet = emitterDrive ? (smokeOn | highGainCap) : toggle_q;
    // wired-or line with pull-down, a remote unit may drive it high
    assign ioLine = (ioOe & ioOut) | remoteOn;
endmodule

// file: verification/testbench.sv
// self-checking bench for the sequencer with a far-side model
// assumes short oscillator parameters: one frame is 4096 * P clocks
`define CHK(nm, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("BAD %s exp=%0d got=%0d", nm, (exp), (got)); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sats_pkg::*;
    localparam int P = 4;
    localparam int D = 1;
    localparam int EM = 0, ST = 1, LD = 2, HN = 3, IO = 4, HG = 5;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        testBtn = 1'b0;
    logic        lowSup = 1'b0;
    logic        smokeOn = 1'b0;
    logic        remoteOn = 1'b0;
    logic        smokeDet, ioLine, emitterDrive, strobeOut, indicatorOutput;
    logic        indicatorOutputOe, hornDrive, ioOut, ioOe, highGainCap;
    logic        normalGainCap, hysteresisBoost;
    sats_sense_t sense;
    logic [5:0]  mon;
    int          n_fail = 0;
    int          checks = 0;

    // clock and sense assembly
    always #5 ref_clk = ~ref_clk;
    assign sense = {testBtn, smokeDet, lowSup, ioLine};
    assign mon = {highGainCap, ioOe, hornDrive, indicatorOutputOe,
                  strobeOut, emitterDrive};

    sats_sequencer #(.OSC_PERIOD_CYC(P), .DISCH_CYC(D)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sense(sense),
        .emitterDrive(emitterDrive), .strobeOut(strobeOut),
        .indicatorOutput(indicatorOutput),
        .indicatorOutputOe(indicatorOutputOe), .hornDrive(hornDrive),
        .ioOut(ioOut), .ioOe(ioOe), .highGainCap(highGainCap),
        .normalGainCap(normalGainCap), .hysteresisBoost(hysteresisBoost));
    sats_far_side i_far (
        .ref_clk(ref_clk), .emitterDrive(emitterDrive),
        .highGainCap(highGainCap), .ioOut(ioOut), .ioOe(ioOe),
        .smokeOn(smokeOn), .remoteOn(remoteOn), .smokeDet(smokeDet),
        .ioLine(ioLine));

    // wait, bounded, until a watched output reaches a level
    task automatic waitv(input int idx, input logic v, input int lim,
                         output int n);
        n = 0;
        while (mon[idx] !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // length in clocks of the run of a level that is present now
    task automatic runlen(input int idx, input logic v, output int n);
        n = 0;
        while (mon[idx] === v && n < 100000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic t_reset();
        `CHK("reset", 8'h02, {mon, normalGainCap, hysteresisBoost});
        `CHK("led data", 1'b0, indicatorOutput);
    endtask
    task automatic t_lowsup();
        int n, w;
        @(posedge ref_clk);
        lowSup <= 1'b1;
        @(negedge ref_clk);
        waitv(ST, 1'b1, 20 * P, n);
        runlen(ST, 1'b1, w);
        `CHK("supply strobe", P, w);
        waitv(HN, 1'b1, 4200 * P, n);
        `CHK("chirp seen", 1, n < 4200 * P);
        runlen(HN, 1'b1, w);
        `CHK("chirp width", P, w);
        @(posedge ref_clk);
        lowSup <= 1'b0;
    endtask
    task automatic t_chamber();
        int n, w;
        waitv(HG, 1'b1, 4200 * P, n);
        `CHK("chamber seen", 1, n < 4200 * P);
        `CHK("chamber strobe", 1'b1, strobeOut);
        `CHK("normal off", 1'b0, normalGainCap);
        runlen(EM, 1'b0, n);
        `CHK("emitter start", P - D, n);
        runlen(EM, 1'b1, w);
        `CHK("emitter width", D, w);
        `CHK("gain one period", 1'b0, highGainCap);
    endtask
    task automatic t_smoke();
        int n, w;
        @(posedge ref_clk);
        smokeOn <= 1'b1;
        @(negedge ref_clk);
        waitv(IO, 1'b1, 3000 * P, n);
        `CHK("local alarm", 1, n < 3000 * P);
        waitv(HN, 1'b1, 4 * P, n);
        runlen(HN, 1'b1, w);
        // the first burst may be clipped, so judge from its end
        for (int i = 0; i < 5; i++) begin
            runlen(HN, i[0], w);
            `CHK("horn run", (i == 4 ? 192 : 64) * P, w);
        end
        waitv(LD, 1'b1, 80 * P, n);
        runlen(LD, 1'b1, w);
        `CHK("led width", P, w);
        runlen(LD, 1'b0, n);
        `CHK("led fast gap", 63 * P, n);
        // next smoke test while alarmed carries the hysteresis boost
        waitv(EM, 1'b1, 1100 * P, n);
        `CHK("boost pulse", 1'b1, hysteresisBoost);
        @(posedge ref_clk);
        smokeOn <= 1'b0;
        waitv(IO, 1'b0, 8000 * P, n);
        `CHK("smoke cleared", 1, n < 8000 * P);
    endtask
    task automatic t_button();
        int n, w;
        @(posedge ref_clk);
        testBtn <= 1'b1;
        @(negedge ref_clk);
        waitv(HG, 1'b1, 3 * P, n);
        `CHK("test gain", 1, n < 3 * P);
        waitv(EM, 1'b1, 130 * P, n);
        runlen(EM, 1'b1, w);
        runlen(EM, 1'b0, n);
        `CHK("test emitter gap", 128 * P, w + n);
        waitv(IO, 1'b1, 4 * P, n);
        `CHK("test drives line", 1, n < 4 * P);
        waitv(HN, 1'b1, 4 * P, n);
        `CHK("test horn", 1, n < 4 * P);
        @(posedge ref_clk);
        testBtn <= 1'b0;
        @(negedge ref_clk);
        waitv(HG, 1'b0, 3 * P, n);
        `CHK("gain back", 1, n < 3 * P);
        waitv(IO, 1'b0, 8000 * P, n);
        `CHK("test exit", 1, n < 8000 * P);
    endtask
    task automatic t_remote();
        int n;
        @(posedge ref_clk);
        remoteOn <= 1'b1;
        @(negedge ref_clk);
        waitv(HN, 1'b1, 400 * P, n);
        `CHK("remote alarm", 1, n < 400 * P);
        `CHK("remote no drive", 1'b0, ioOe);
        waitv(LD, 1'b1, 100 * P, n);
        `CHK("remote no led", 100 * P, n);
    endtask

    // emitter stays clear of indicator and horn, boost rides on smoke
    always @(negedge ref_clk) begin
        if (rst_n && emitterDrive === 1'b1) begin
            `CHK("overlap", 1'b0, indicatorOutputOe | hornDrive);
            if (smokeOn && ioOe === 1'b1 && normalGainCap === 1'b1)
                `CHK("boost", 1'b1, hysteresisBoost);
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, well past the expected run length
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_fail++;
        $display("BAD watchdog exp=done got=hang");
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_lowsup();
        t_chamber();
        t_smoke();
        t_button();
        t_remote();
        report_and_stop();
    end
endmodule
